// ### hdl/dma_guard_host.sv
// Bus master that applies software orders to the DMA controller safely.
//
// Functional notes
// - Configure only when reset or channel disabled.
// - Enabled: only enable, request, interrupt, count.
// - Device ignores count writes while enabled.
// - Request flag clears on zero, ignores one.
// - Control write keeps all other bits.
// - DMA may rewrite other channel addresses.
// - DMA never targets its own channel.
// - Status write of one has no effect.
// - Clear status by writing one elsewhere.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module dma_guard_host (
  dma_guard_if.host bus,
  input wire logic [4:0] sw_addr,
  input wire logic [dma_guard_pkg::DATA_W-1:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [dma_guard_pkg::DATA_W-1:0] sw_rdata,
  output logic host_irq
);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [dma_guard_pkg::ADDR_W-1:0] taddr;
  logic [dma_guard_pkg::DATA_W-1:0] tdata;
  logic [1:0] op;
  logic via_dma;
  logic origin;
  logic [dma_guard_pkg::DATA_W-1:0] result;
  logic [dma_guard_pkg::HI_W-1:0] hist;
  logic [dma_guard_pkg::HI_W-1:0] himask;
  dma_guard_pkg::host_state_t state;
  dma_guard_pkg::host_state_t next_state;

  // Software write decode; a command is only taken while idle.
  wire busy = (state != dma_guard_pkg::S_IDLE);
  wire go = sw_wr && (sw_addr == dma_guard_pkg::H_CMD) && !busy;
  wire wr_taddr = sw_wr && (sw_addr == dma_guard_pkg::H_TADDR) && !busy;
  wire wr_tdata = sw_wr && (sw_addr == dma_guard_pkg::H_TDATA) && !busy;
  wire wr_hist = sw_wr && (sw_addr == dma_guard_pkg::H_IST);
  wire wr_himask = sw_wr && (sw_addr == dma_guard_pkg::H_IMASK);
  wire [1:0] go_op = sw_wdata[1:0];

  // ----------------------------------------------------------------
  // Target decode
  // ----------------------------------------------------------------
  // Decode of the latched target address.
  wire tgt_ch_reg = dma_guard_pkg::is_ch_addr(taddr);
  wire tgt_ch = dma_guard_pkg::ch_of(taddr);
  wire [1:0] tgt_sel = dma_guard_pkg::sel_of(taddr);
  wire tgt_is_ctrl = tgt_ch_reg && (tgt_sel == dma_guard_pkg::SEL_CTRL);
  wire tgt_is_cnt = tgt_ch_reg && (tgt_sel == dma_guard_pkg::SEL_CNT);
  wire tgt_is_addr = tgt_ch_reg &&
      ((tgt_sel == dma_guard_pkg::SEL_SRC) || (tgt_sel == dma_guard_pkg::SEL_DST));
  wire [dma_guard_pkg::ADDR_W-1:0] probe_addr =
      tgt_ch ? dma_guard_pkg::OFS_CH_STRIDE : 8'h00;

  // Decode of a command arriving from software, using the target already stored.
  wire go_reads = (go_op == dma_guard_pkg::OP_READ);
  wire go_clr = (go_op == dma_guard_pkg::OP_CLR_IRQ);
  // Unused op codes probe too, so they never reach a channel register unguarded.
  wire go_needs_probe = !go_reads && !go_clr && tgt_ch_reg;

  // ----------------------------------------------------------------
  // Write policy
  // ----------------------------------------------------------------
  // State of the target channel as seen by the probe read.
  wire tgt_en = bus.rdata[dma_guard_pkg::EN_BIT];
  // A channel moving data must never rewrite its own registers.
  wire self_hit = via_dma && (origin == tgt_ch);
  // Addresses of another channel may be rewritten by a DMA move even when enabled.
  wire cross_addr = via_dma && tgt_is_addr && !self_hit;
  // Configuration is touched only while disabled, apart from the listed exceptions.
  wire allowed = !self_hit &&
      (!tgt_en || tgt_is_ctrl || tgt_is_cnt || cross_addr);
  // While enabled, a control write carries back every bit but enable and request.
  wire [dma_guard_pkg::DATA_W-1:0] keep_bits =
      {8'h00, bus.rdata[dma_guard_pkg::CTRL_W-1:0] & dma_guard_pkg::CTRL_KEEP_MASK};
  wire [dma_guard_pkg::DATA_W-1:0] own_bits =
      {8'h00, tdata[dma_guard_pkg::CTRL_W-1:0] & ~dma_guard_pkg::CTRL_KEEP_MASK};
  wire [dma_guard_pkg::DATA_W-1:0] final_wdata =
      (tgt_is_ctrl && tgt_en) ? (keep_bits | own_bits) : tdata;
  // Status bits to keep are written as one, bits to clear as zero.
  wire [dma_guard_pkg::DATA_W-1:0] clr_word = ~sw_wdata;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state of the sequencer.
  always_comb begin
    next_state = state;
    unique case (state)
      dma_guard_pkg::S_IDLE: begin
        if (go) begin
          next_state = (go_needs_probe || go_reads) ?
              dma_guard_pkg::S_PROBE : dma_guard_pkg::S_FINISH;
        end
      end
      dma_guard_pkg::S_PROBE: begin
        next_state = dma_guard_pkg::S_DECIDE;
      end
      dma_guard_pkg::S_DECIDE: begin
        next_state = (op == dma_guard_pkg::OP_WRITE && allowed) ?
            dma_guard_pkg::S_FINISH : dma_guard_pkg::S_IDLE;
      end
      dma_guard_pkg::S_FINISH: begin
        next_state = dma_guard_pkg::S_IDLE;
      end
    endcase
  end

  // Events raised by the sequencer.
  wire ev_done = ((state == dma_guard_pkg::S_DECIDE) && (op == dma_guard_pkg::OP_READ)) ||
                 (state == dma_guard_pkg::S_FINISH);
  wire ev_refused = (state == dma_guard_pkg::S_DECIDE) &&
                    (op == dma_guard_pkg::OP_WRITE) && !allowed;

  // Sequencer state and bus strobes.
  always_ff @(posedge bus.mclk or posedge bus.reset) begin
    if (bus.reset) begin
      state <= dma_guard_pkg::S_IDLE;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      bus.addr <= 8'h00;
      bus.wdata <= dma_guard_pkg::WORD_RST;
    end else begin
      state <= next_state;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      if (go && (go_needs_probe || go_reads)) begin
        bus.rd <= 1'b1;
        bus.addr <= go_reads ? taddr : probe_addr;
      end else if (go) begin
        bus.wr <= 1'b1;
        bus.addr <= go_clr ? dma_guard_pkg::OFS_ISTAT : taddr;
        bus.wdata <= go_clr ? clr_word : tdata;
      end else if (state == dma_guard_pkg::S_DECIDE && next_state == dma_guard_pkg::S_FINISH) begin
        bus.wr <= 1'b1;
        bus.addr <= taddr;
        bus.wdata <= final_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software register file
  // ----------------------------------------------------------------
  // Sticky events: a new event wins over a write-one clear in the same cycle.
  wire [dma_guard_pkg::HI_W-1:0] hist_set = {ev_refused, ev_done};
  wire [dma_guard_pkg::HI_W-1:0] hist_clr =
      wr_hist ? sw_wdata[dma_guard_pkg::HI_W-1:0] : dma_guard_pkg::HI_RST;
  wire [dma_guard_pkg::HI_W-1:0] next_hist = hist_set | (hist & ~hist_clr);

  // Read selection for the software port.
  wire [dma_guard_pkg::DATA_W-1:0] sw_mux =
      (sw_addr == dma_guard_pkg::H_TADDR) ? {8'h00, taddr} :
      (sw_addr == dma_guard_pkg::H_TDATA) ? tdata :
      (sw_addr == dma_guard_pkg::H_CMD) ? {12'h000, origin, via_dma, op} :
      (sw_addr == dma_guard_pkg::H_STAT) ? {14'h0000, bus.irq, busy} :
      (sw_addr == dma_guard_pkg::H_RESULT) ? result :
      (sw_addr == dma_guard_pkg::H_IST) ? {14'h0000, hist} :
      (sw_addr == dma_guard_pkg::H_IMASK) ? {14'h0000, himask} : dma_guard_pkg::WORD_RST;

  // Command latches and result capture.
  always_ff @(posedge bus.mclk or posedge bus.reset) begin
    if (bus.reset) begin
      taddr <= 8'h00;
      tdata <= dma_guard_pkg::WORD_RST;
      op <= dma_guard_pkg::OP_WRITE;
      via_dma <= 1'b0;
      origin <= 1'b0;
      result <= dma_guard_pkg::WORD_RST;
    end else begin
      if (wr_taddr) begin
        taddr <= sw_wdata[dma_guard_pkg::ADDR_W-1:0];
      end
      if (wr_tdata) begin
        tdata <= sw_wdata;
      end
      if (go) begin
        op <= go_op;
        via_dma <= sw_wdata[dma_guard_pkg::VIA_DMA_BIT];
        origin <= sw_wdata[dma_guard_pkg::ORIGIN_BIT];
      end
      if (state == dma_guard_pkg::S_DECIDE && op == dma_guard_pkg::OP_READ) begin
        result <= bus.rdata;
      end
    end
  end

  // Interrupt status, mask, read data and interrupt output.
  always_ff @(posedge bus.mclk or posedge bus.reset) begin
    if (bus.reset) begin
      hist <= dma_guard_pkg::HI_RST;
      himask <= dma_guard_pkg::HI_RST;
      sw_rdata <= dma_guard_pkg::WORD_RST;
      host_irq <= 1'b0;
    end else begin
      hist <= next_hist;
      if (wr_himask) begin
        himask <= sw_wdata[dma_guard_pkg::HI_W-1:0];
      end
      sw_rdata <= sw_rd ? sw_mux : dma_guard_pkg::WORD_RST;
      host_irq <= |(next_hist & himask);
    end
  end

endmodule // dma_guard_host

// ### hdl/dma_guard_pkg.sv
// Shared constants, address decoding and types for the DMA register write guard.
package dma_guard_pkg;

  // ----------------------------------------------------------------
  // Widths and channel count
  // ----------------------------------------------------------------
  localparam int NUM_CH = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CTRL_W = 8;

  // ----------------------------------------------------------------
  // Device register map
  // ----------------------------------------------------------------
  // Channel registers sit at channel * 16 plus the select offset.
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_SRC = 2'h1;
  localparam logic [1:0] SEL_DST = 2'h2;
  localparam logic [1:0] SEL_CNT = 2'h3;
  localparam logic [7:0] OFS_CH_STRIDE = 8'h10;
  localparam logic [7:0] OFS_ISTAT = 8'h40;
  localparam logic [7:0] OFS_IMASK = 8'h44;

  // Channel control register fields.
  localparam int EN_BIT = 0;
  localparam int REQ_BIT = 1;
  localparam logic [CTRL_W-1:0] CTRL_KEEP_MASK = 8'hFC;

  // Values after reset.
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
  localparam logic [NUM_CH-1:0] IRQ_RST = 2'h0;

  // ----------------------------------------------------------------
  // Host software register map
  // ----------------------------------------------------------------
  localparam logic [4:0] H_TADDR = 5'h00;
  localparam logic [4:0] H_TDATA = 5'h04;
  localparam logic [4:0] H_CMD = 5'h08;
  localparam logic [4:0] H_STAT = 5'h0C;
  localparam logic [4:0] H_RESULT = 5'h10;
  localparam logic [4:0] H_IST = 5'h14;
  localparam logic [4:0] H_IMASK = 5'h18;

  // Command word fields and operations.
  localparam int VIA_DMA_BIT = 2;
  localparam int ORIGIN_BIT = 3;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_CLR_IRQ = 2'h2;

  // Host interrupt status bits.
  localparam int HI_W = 2;
  localparam int HI_DONE = 0;
  localparam int HI_REFUSED = 1;
  localparam logic [HI_W-1:0] HI_RST = 2'h0;

  typedef enum {S_IDLE, S_PROBE, S_DECIDE, S_FINISH} host_state_t;

  // ----------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------
  // True when the address names a channel register.
  function automatic logic is_ch_addr(input logic [ADDR_W-1:0] a);
    return (a[7:5] == 3'h0) && (a[1:0] == 2'h0);
  endfunction

  // Channel number of a channel register address.
  function automatic logic ch_of(input logic [ADDR_W-1:0] a);
    return a[4];
  endfunction

  // Register select within a channel.
  function automatic logic [1:0] sel_of(input logic [ADDR_W-1:0] a);
    return a[3:2];
  endfunction

endpackage

// ### hdl/dma_guard_if.sv
// Register bus between the DMA controller and its bus master.
`timescale 1ns/1ps
interface dma_guard_if (
  input wire logic mclk,
  input wire logic reset
);
  logic wr;
  logic rd;
  logic [dma_guard_pkg::ADDR_W-1:0] addr;
  logic [dma_guard_pkg::DATA_W-1:0] wdata;
  logic [dma_guard_pkg::DATA_W-1:0] rdata;
  logic irq;

  modport dev (
    input mclk, reset, wr, rd, addr, wdata,
    output rdata, irq
  );

  modport host (
    input mclk, reset, rdata, irq,
    output wr, rd, addr, wdata
  );
endinterface

// ### hdl/dma_guard_dev.sv
// DMA controller register file with write guarding during active transfers.
`timescale 1ns/1ps
module dma_guard_dev (
  dma_guard_if.dev bus,
  input wire logic [dma_guard_pkg::NUM_CH-1:0] xfer_trig,
  output logic [dma_guard_pkg::NUM_CH-1:0] xfer_ack,
  output logic [dma_guard_pkg::NUM_CH-1:0] chan_busy
);

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  // Common decode of the bus address.
  wire ch_addr = dma_guard_pkg::is_ch_addr(bus.addr);
  wire addr_ch = dma_guard_pkg::ch_of(bus.addr);
  wire [1:0] addr_sel = dma_guard_pkg::sel_of(bus.addr);
  wire wr_istat = bus.wr && (bus.addr == dma_guard_pkg::OFS_ISTAT);
  wire wr_imask = bus.wr && (bus.addr == dma_guard_pkg::OFS_IMASK);

  // Per-channel storage is unpacked so that each channel's process owns its own element.
  logic [dma_guard_pkg::CTRL_W-1:0] ctrl [dma_guard_pkg::NUM_CH];
  logic [dma_guard_pkg::DATA_W-1:0] src [dma_guard_pkg::NUM_CH];
  logic [dma_guard_pkg::DATA_W-1:0] dst [dma_guard_pkg::NUM_CH];
  logic [dma_guard_pkg::DATA_W-1:0] cnt [dma_guard_pkg::NUM_CH];
  logic [dma_guard_pkg::NUM_CH-1:0] istat;
  logic [dma_guard_pkg::NUM_CH-1:0] imask;
  wire [dma_guard_pkg::NUM_CH-1:0] done;
  wire [dma_guard_pkg::NUM_CH-1:0] serve;
  wire [dma_guard_pkg::NUM_CH-1:0][dma_guard_pkg::DATA_W-1:0] ch_rd;

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < dma_guard_pkg::NUM_CH; g++) begin : g_ch
    wire hit = bus.wr && ch_addr && (addr_ch == g);
    wire hit_ctrl = hit && (addr_sel == dma_guard_pkg::SEL_CTRL);
    wire hit_src = hit && (addr_sel == dma_guard_pkg::SEL_SRC);
    wire hit_dst = hit && (addr_sel == dma_guard_pkg::SEL_DST);
    wire en = ctrl[g][dma_guard_pkg::EN_BIT];
    wire req = ctrl[g][dma_guard_pkg::REQ_BIT];
    // The count is only written while the channel is disabled.
    wire hit_cnt = hit && (addr_sel == dma_guard_pkg::SEL_CNT) && !en;
    // A written zero or a served request clears the request flag; a written one leaves it alone.
    wire req_wr_clr = hit_ctrl && !bus.wdata[dma_guard_pkg::REQ_BIT];
    // A new trigger wins over a clear arriving in the same cycle.
    wire next_req = (en && xfer_trig[g]) || (req && !req_wr_clr && !serve[g]);
    wire next_en = hit_ctrl ? bus.wdata[dma_guard_pkg::EN_BIT] : (en && !done[g]);
    wire [dma_guard_pkg::CTRL_W-1:0] next_ctrl = hit_ctrl ?
        {bus.wdata[dma_guard_pkg::CTRL_W-1:2], next_req, next_en} :
        {ctrl[g][dma_guard_pkg::CTRL_W-1:2], next_req, next_en};

    // One unit is moved per serviced request; the last one ends the transfer.
    assign serve[g] = en && req && (cnt[g] != dma_guard_pkg::WORD_RST);
    assign done[g] = serve[g] && (cnt[g] == 16'h0001);
    assign ch_rd[g] = (addr_sel == dma_guard_pkg::SEL_CTRL) ? {8'h00, ctrl[g]} :
                      (addr_sel == dma_guard_pkg::SEL_SRC) ? src[g] :
                      (addr_sel == dma_guard_pkg::SEL_DST) ? dst[g] : cnt[g];

    // Channel register state.
    always_ff @(posedge bus.mclk or posedge bus.reset) begin
      if (bus.reset) begin
        ctrl[g] <= dma_guard_pkg::CTRL_RST;
        src[g] <= dma_guard_pkg::WORD_RST;
        dst[g] <= dma_guard_pkg::WORD_RST;
        cnt[g] <= dma_guard_pkg::WORD_RST;
      end else begin
        ctrl[g] <= next_ctrl;
        if (hit_src) begin
          src[g] <= bus.wdata;
        end
        if (hit_dst) begin
          dst[g] <= bus.wdata;
        end
        if (hit_cnt) begin
          cnt[g] <= bus.wdata;
        end else if (serve[g]) begin
          cnt[g] <= cnt[g] - 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and read port
  // ----------------------------------------------------------------
  // Writing zero clears a status bit, writing one keeps it; completion wins.
  wire [dma_guard_pkg::NUM_CH-1:0] istat_clr =
      wr_istat ? ~bus.wdata[dma_guard_pkg::NUM_CH-1:0] : '0;
  wire [dma_guard_pkg::NUM_CH-1:0] next_istat = done | (istat & ~istat_clr);
  wire [dma_guard_pkg::DATA_W-1:0] rd_mux =
      ch_addr ? ch_rd[addr_ch] :
      (bus.addr == dma_guard_pkg::OFS_ISTAT) ? {14'h0000, istat} :
      (bus.addr == dma_guard_pkg::OFS_IMASK) ? {14'h0000, imask} : dma_guard_pkg::WORD_RST;

  // Status, mask, read data and user outputs.
  always_ff @(posedge bus.mclk or posedge bus.reset) begin
    if (bus.reset) begin
      istat <= dma_guard_pkg::IRQ_RST;
      imask <= dma_guard_pkg::IRQ_RST;
      bus.irq <= 1'b0;
      bus.rdata <= dma_guard_pkg::WORD_RST;
      xfer_ack <= dma_guard_pkg::IRQ_RST;
      chan_busy <= dma_guard_pkg::IRQ_RST;
    end else begin
      istat <= next_istat;
      if (wr_imask) begin
        imask <= bus.wdata[dma_guard_pkg::NUM_CH-1:0];
      end
      bus.irq <= |(next_istat & imask);
      bus.rdata <= bus.rd ? rd_mux : dma_guard_pkg::WORD_RST;
      xfer_ack <= serve;
      chan_busy <= {ctrl[1][dma_guard_pkg::EN_BIT], ctrl[0][dma_guard_pkg::EN_BIT]};
    end
  end

endmodule // dma_guard_dev

// ### testbench/dma_guard_monitor.sv
// Concurrent checks on the register bus that joins the host and the device.
`timescale 1ns/1ps
module dma_guard_monitor (
  input wire logic mclk,
  input wire logic reset,
  input wire logic wr,
  input wire logic rd,
  input wire logic [dma_guard_pkg::ADDR_W-1:0] addr,
  input wire logic [dma_guard_pkg::DATA_W-1:0] wdata,
  input wire logic [dma_guard_pkg::DATA_W-1:0] rdata,
  input wire logic irq
);
  // Decode the bus address into channel, control and unmapped places.
  wire ch_hit = (addr[7:5] == 3'h0) && (addr[1:0] == 2'h0);
  wire ctrl_hit = ch_hit && (addr[3:2] == 2'h0);
  wire unmapped = !ch_hit && (addr != dma_guard_pkg::OFS_ISTAT) &&
                  (addr != dma_guard_pkg::OFS_IMASK);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Bus strobes and read data
  // ----------------------------------------------------------------
  property p_strobe_excl; !(wr && rd); endproperty
  a_strobe_excl: assert property (p_strobe_excl)
    else $error("Write and read strobes high together.");
  property p_wr_pulse; wr |=> !wr; endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("Write strobe longer than one cycle.");
  property p_rd_pulse; rd |=> !rd; endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("Read strobe longer than one cycle.");
  property p_rdata_idle; !rd |=> rdata == 16'h0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("Read data not zero outside the answer cycle.");
  property p_unmapped_read; rd && unmapped |=> rdata == 16'h0000; endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("Unmapped read returned nonzero data.");

  // ----------------------------------------------------------------
  // Host write policy
  // ----------------------------------------------------------------
  property p_probe_first;
    wr && ch_hit |-> $past(rd, 2) && ($past(addr, 2) == {addr[7:4], 4'h0});
  endproperty
  a_probe_first: assert property (p_probe_first)
    else $error("Channel write without a prior enable probe.");
  property p_probe_gap; rd && ctrl_hit |=> !wr; endproperty
  a_probe_gap: assert property (p_probe_gap)
    else $error("Write issued before the probe answer arrived.");
  property p_ctrl_keep;
    wr && ctrl_hit && $past(rdata[0]) |-> wdata[15:2] == $past(rdata[15:2]);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep)
    else $error("Control write while enabled changed other bits.");

  // Main scenarios seen on the bus.
  c_ctrl_keep: cover property (wr && ctrl_hit && $past(rdata[0]));
  c_istat_wr: cover property (wr && addr == dma_guard_pkg::OFS_ISTAT);
  c_irq: cover property ($rose(irq));
endmodule // dma_guard_monitor

// ### testbench/test_dma_register_write_guard.sv
// Self-checking bench for the host and device ends of the DMA write guard.
`timescale 1ns/1ps
module test_dma_register_write_guard;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] sw_addr = 5'h00;
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [1:0] xfer_trig = 2'h0;
  wire [15:0] sw_rdata;
  wire host_irq;
  wire [1:0] xfer_ack;
  wire [1:0] chan_busy;
  int miscompares = 0;
  int total_checks = 0;
  int acks [2] = '{0, 0};
  logic [15:0] v;
  logic [15:0] h;
  // Rows of target address, written word and expected read back.
  logic [47:0] rows [9] = '{48'h0004_1234_1234, 48'h0008_2345_2345, 48'h000C_0002_0002,
    48'h0014_3456_3456, 48'h0018_4567_4567, 48'h001C_0000_0000, 48'h0044_0003_0003,
    48'h0000_0002_0000, 48'h0080_BEEF_0000};

  // Free-running system clock.
  initial begin
    forever #50 mclk = ~mclk;
  end

  dma_guard_if u_dma_guard_if (.mclk(mclk), .reset(reset));
  dma_guard_dev u_dma_guard_dev (.bus(u_dma_guard_if.dev), .xfer_trig(xfer_trig),
    .xfer_ack(xfer_ack), .chan_busy(chan_busy));
  dma_guard_host u_dma_guard_host (.bus(u_dma_guard_if.host), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .host_irq(host_irq));
  dma_guard_monitor u_dma_guard_monitor (.mclk(mclk), .reset(reset),
    .wr(u_dma_guard_if.wr), .rd(u_dma_guard_if.rd), .addr(u_dma_guard_if.addr),
    .wdata(u_dma_guard_if.wdata), .rdata(u_dma_guard_if.rdata), .irq(u_dma_guard_if.irq));

  // Count served units per channel.
  always @(posedge mclk) begin
    if (xfer_ack[0] === 1'b1) acks[0]++;
    if (xfer_ack[1] === 1'b1) acks[1]++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic sw_put(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge mclk);
    sw_wr <= 1'b0;
  endtask

  task automatic sw_get(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge mclk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask

  // Issue one host command, wait for idle and return the host interrupt status bits.
  task automatic cmd(input logic [3:0] c, input logic [15:0] a, input logic [15:0] d,
      output logic [15:0] st);
    logic [15:0] s;
    sw_put(dma_guard_pkg::H_IST, 16'h0003);
    sw_put(dma_guard_pkg::H_TADDR, a);
    sw_put(dma_guard_pkg::H_TDATA, d);
    sw_put(dma_guard_pkg::H_CMD, {12'h000, c});
    s = 16'h0001;
    for (int i = 0; i < 20 && s[0] !== 1'b0; i++) sw_get(dma_guard_pkg::H_STAT, s);
    chk(s & 16'h0001, 16'h0000, "host idle");
    sw_get(dma_guard_pkg::H_IST, st);
  endtask

  task automatic rd_dev(input logic [15:0] a, output logic [15:0] d);
    logic [15:0] st;
    cmd(4'h1, a, 16'h0000, st);
    sw_get(dma_guard_pkg::H_RESULT, d);
  endtask

  task automatic pulse(input logic [1:0] m);
    @(posedge mclk);
    xfer_trig <= m;
    @(posedge mclk);
    xfer_trig <= 2'h0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Cut a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    #1;
    chk({15'h0000, host_irq}, 16'h0000, "host irq after reset");
    chk({14'h0000, chan_busy}, 16'h0000, "busy after reset");
    $display("test reset done");
    foreach (rows[i]) begin
      cmd(4'h0, rows[i][47:32], rows[i][31:16], h);
      chk(h, 16'h0001, "write done");
      rd_dev(rows[i][47:32], v);
      chk(v, rows[i][15:0], "read back");
    end
    $display("test table done");
    cmd(4'h0, 16'h0010, 16'h0001, h);
    pulse(2'h2);
    rd_dev(16'h0010, v);
    chk(v, 16'h0003, "request set by trigger");
    cmd(4'h0, 16'h0010, 16'h0003, h);
    rd_dev(16'h0010, v);
    chk(v, 16'h0003, "request kept on one");
    cmd(4'h0, 16'h0010, 16'h0001, h);
    rd_dev(16'h0010, v);
    chk(v, 16'h0001, "request cleared on zero");
    cmd(4'h0, 16'h0010, 16'h0000, h);
    cmd(4'h0, 16'h001C, 16'h0001, h);
    cmd(4'h0, 16'h0010, 16'h0001, h);
    pulse(2'h2);
    rd_dev(16'h0010, v);
    chk(v, 16'h0000, "enable cleared at end");
    chk(16'(acks[1]), 16'h0001, "channel one served");
    $display("test request flag done");
    cmd(4'h0, 16'h0000, 16'h00A5, h);
    chk({14'h0000, chan_busy}, 16'h0001, "busy follows enable");
    cmd(4'h0, 16'h000C, 16'h0055, h);
    chk(h, 16'h0001, "count write passed");
    rd_dev(16'h000C, v);
    chk(v, 16'h0002, "count protected");
    cmd(4'h0, 16'h0004, 16'h7777, h);
    chk(h, 16'h0002, "source write refused");
    rd_dev(16'h0004, v);
    chk(v, 16'h1234, "source unchanged");
    cmd(4'hC, 16'h0004, 16'h5A5A, h);
    chk(h, 16'h0001, "cross channel write");
    rd_dev(16'h0004, v);
    chk(v, 16'h5A5A, "cross channel value");
    cmd(4'h3, 16'h0004, 16'h1111, h);
    chk(h, 16'h0000, "unused op ignored");
    rd_dev(16'h0004, v);
    chk(v, 16'h5A5A, "unused op wrote nothing");
    cmd(4'h4, 16'h0008, 16'h6666, h);
    chk(h, 16'h0002, "own channel write refused");
    cmd(4'h0, 16'h0000, 16'h0001, h);
    rd_dev(16'h0000, v);
    chk(v, 16'h00A5, "mode bits kept");
    pulse(2'h1);
    pulse(2'h1);
    chk(16'(acks[0]), 16'h0002, "channel zero served");
    rd_dev(16'h0000, v);
    chk(v, 16'h00A4, "enable cleared at end");
    chk({14'h0000, chan_busy}, 16'h0000, "busy dropped");
    $display("test active channel done");
    rd_dev(16'h0040, v);
    chk(v, 16'h0003, "both channels finished");
    sw_get(dma_guard_pkg::H_STAT, v);
    chk(v & 16'h0002, 16'h0002, "device irq seen");
    cmd(4'h2, 16'h0000, 16'h0000, h);
    rd_dev(16'h0040, v);
    chk(v, 16'h0001, "one keeps, zero clears");
    chk({15'h0000, host_irq}, 16'h0000, "host irq masked");
    sw_put(dma_guard_pkg::H_IMASK, 16'h0001);
    @(posedge mclk);
    #1;
    chk({15'h0000, host_irq}, 16'h0001, "host irq raised");
    sw_put(dma_guard_pkg::H_IST, 16'h0001);
    @(posedge mclk);
    #1;
    chk({15'h0000, host_irq}, 16'h0000, "host irq cleared");
    $display("test interrupts done");
    @(posedge mclk);
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    rd_dev(16'h0000, v);
    chk(v, 16'h0000, "control after second reset");
    $display("test second reset done");
    report_and_stop;
  end
endmodule // test_dma_register_write_guard
